// >>> core/ess_chk_if.sv
// Carrier between the control block and the page content checker
`timescale 1ns/10ps
`default_nettype none
interface ess_chk_if;
	logic clear;
	logic wordValid;
	logic [31:0] wordData;
	logic [31:0] pageLa;
	logic restZero;
	logic firstOk;
	modport ctrl (output clear, output wordValid, output wordData, output pageLa,
		input restZero, input firstOk);
	modport chk (input clear, input wordValid, input wordData, input pageLa,
		output restZero, output firstOk);
endinterface
`default_nettype wire

// >>> core/ess_page_check.sv
// Streaming content check of a page offered for creation
`timescale 1ns/10ps
`default_nettype none
module ess_page_check (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Word stream and verdicts
	ess_chk_if.chk chk
);
	logic [10:0] idx_r;
	logic zeroAll_r;
	logic zeroOut_r;
	logic [31:0] tokLo_r;
	logic [31:0] tokHi_r;
	logic complete;
	logic [31:0] tokExpect;

	// ==========================================================
	// Accumulate zero flags and the token words
	always_ff @(posedge clk_sys) begin
		if (!rst_n || chk.clear) begin
			idx_r <= 11'h000;
			zeroAll_r <= 1'b1;
			zeroOut_r <= 1'b1;
			tokLo_r <= ess_pkg::RST_WORD;
			tokHi_r <= ess_pkg::RST_WORD;
		end else if (chk.wordValid && !complete) begin
			idx_r <= idx_r + 11'h001;
			if (chk.wordData != ess_pkg::RST_WORD) begin
				zeroAll_r <= 1'b0;
			end
			if (idx_r[9:0] == ess_pkg::TOKEN_WORD_LO) begin
				tokLo_r <= chk.wordData;
			end else if (idx_r[9:0] == ess_pkg::TOKEN_WORD_HI) begin
				tokHi_r <= chk.wordData;
			end else if (chk.wordData != ess_pkg::RST_WORD) begin
				zeroOut_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Verdicts, valid only once a whole page has streamed in
	assign complete = (idx_r == ess_pkg::PAGE_WORDS);
	assign tokExpect = chk.pageLa + ess_pkg::PAGE_SIZE;
	assign chk.restZero = complete && zeroAll_r;
	assign chk.firstOk = complete && zeroOut_r && (tokHi_r == ess_pkg::RST_WORD)
		&& (tokLo_r == tokExpect);
endmodule
`default_nettype wire

// >>> core/ess_pkg.sv
// Shared constants and types for the enclave shadow-stack support block
package ess_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RANGE_BASE = 8'h08;
	localparam logic [7:0] OFS_RANGE_END = 8'h0c;
	localparam logic [7:0] OFS_TGT_LA = 8'h10;
	localparam logic [7:0] OFS_TGT_SLOT = 8'h14;
	localparam logic [7:0] OFS_PAGE_INFO = 8'h18;
	localparam logic [7:0] OFS_CF_LIVE = 8'h1c;
	localparam logic [7:0] OFS_CF_ENCL = 8'h20;
	localparam logic [7:0] OFS_SSP = 8'h24;
	localparam logic [7:0] OFS_TCS_PREV = 8'h28;
	localparam logic [7:0] OFS_SSA_CF = 8'h2c;
	localparam logic [7:0] OFS_CONTENT = 8'h30;
	localparam logic [7:0] OFS_ACC_KIND = 8'h34;
	localparam logic [7:0] OFS_PFEC = 8'h38;
	localparam logic [7:0] OFS_MAP_READ = 8'h3c;
	localparam logic [7:0] OFS_TCS_NEW = 8'h40;
	localparam logic [7:0] OFS_SSA_SSP = 8'h44;

	// ==========================================================
	// Field positions
	localparam int INFO_PERM_LSB = 0;
	localparam int INFO_TYPE_LSB = 3;
	localparam int INFO_PRESENT_BIT = 8;
	localparam int PERM_R_BIT = 0;
	localparam int PERM_W_BIT = 1;
	localparam int ST_ENCL_BIT = 4;
	localparam int MAP_VALID_BIT = 8;
	localparam int PFEC_P_BIT = 0;
	localparam int PFEC_WR_BIT = 1;
	localparam int PFEC_ENCL_BIT = 15;

	// ==========================================================
	// Reset values and page geometry
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [2:0] PERM_RW = 3'h3;
	localparam logic [31:0] PAGE_SIZE = 32'h0000_1000;
	localparam logic [31:0] PAGE_MASK = 32'hffff_f000;
	localparam logic [31:0] TOKEN_OFS = 32'h0000_0ff8;
	localparam logic [10:0] PAGE_WORDS = 11'h400;
	localparam logic [9:0] TOKEN_WORD_LO = 10'h3fe;
	localparam logic [9:0] TOKEN_WORD_HI = 10'h3ff;

	// ==========================================================
	// Enumerations
	typedef enum logic [2:0] {
		PT_NONE = 3'h0,
		PT_REG = 3'h1,
		PT_TCS = 3'h2,
		PT_SS_HEAD = 3'h3,
		PT_SS_TAIL = 3'h4,
		PT_TRIM = 3'h5
	} ess_ptype_t;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ENTER = 4'h1,
		OP_EXIT = 4'h2,
		OP_AEX = 4'h3,
		OP_ADD = 4'h4,
		OP_AUG = 4'h5,
		OP_ACCEPT = 4'h6,
		OP_ACCEPT_COPY = 4'h7,
		OP_RESTRICT = 4'h8,
		OP_EXTEND = 4'h9,
		OP_ACCESS = 4'ha,
		OP_CLEAR = 4'hb
	} ess_op_t;

	typedef enum logic [3:0] {
		RES_OK = 4'h0,
		RES_ERR_POS = 4'h1,
		RES_ERR_CONTENT = 4'h2,
		RES_ERR_PARAM = 4'h3,
		RES_ERR_TYPE = 4'h4,
		RES_ERR_TCS = 4'h5,
		RES_ERR_MODE = 4'h6,
		RES_FAULT_GP = 4'h7,
		RES_FAULT_PF = 4'h8
	} ess_res_t;

	typedef enum logic [1:0] {
		ACC_LOAD = 2'h0,
		ACC_STORE = 2'h1,
		ACC_SS_LOAD = 2'h2,
		ACC_SS_STORE = 2'h3
	} ess_acc_t;

endpackage

// >>> core/ess_shadow_ctrl.sv
// Enclave shadow-stack control: state swap, page map, page creation checks
//
// Notes on behaviour
// - Entry saves host state, loads enclave state
// - Asynchronous exit saves enclave state to frame
// - Any exit restores host state from scratch
// - Map holds first and rest shadow types
// - Shadow pages: shadow ops, loads; no stores
// - Shadow pages mapped writable by page tables
// - In enclave, shadow ops stay in range
// - Augmenting shadow page needs info, read/write
// - Null info augments ordinary read/write page
// - Augmented first page gets token at 0xff8
// - No shadow page at range ends
// - Added rest page must be all zero
// - Added first page zero except token
// - Token address equals page address plus 4096
// - Entry loads pointer from thread structure field
// - Exit stores pointer into thread structure field
// - Thread structure add/accept needs field zero
// - Copy, restrict, extend refused on shadow pages
// - Shadow op outside range faults general protection
// - Failed map check gives enclave page fault
`timescale 1ns/10ps
`default_nettype none
module ess_shadow_ctrl #(
	parameter int PAGES = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// Live core state
	output logic inEnclave,
	output logic [31:0] cfLive,
	output logic [31:0] sspLive,
	// Fault reporting
	output logic faultGp,
	output logic faultPf,
	output logic [31:0] pfecOut,
	// Restore token write toward memory
	output logic tokWrEn,
	output logic [31:0] tokWrAddr,
	output logic [31:0] tokWrData
);
	localparam int SLOT_W = (PAGES > 1) ? $clog2(PAGES) : 1;

	// ==========================================================
	// Storage
	logic [31:0] rdData_r;
	logic [31:0] base_r;
	logic [31:0] end_r;
	logic [31:0] tgtLa_r;
	logic [SLOT_W-1:0] tgtSlot_r;
	logic [8:0] info_r;
	logic [31:0] cfLive_r;
	logic [31:0] cfEncl_r;
	logic [31:0] cfScratch_r;
	logic [31:0] ssp_r;
	logic [31:0] tcsPrev_r;
	logic [31:0] ssaCf_r;
	logic [31:0] ssaSsp_r;
	logic [31:0] tcsNew_r;
	logic [31:0] pfec_r;
	ess_pkg::ess_acc_t accKind_r;
	ess_pkg::ess_res_t res_r;
	logic inEncl_r;
	logic faultGp_r;
	logic faultPf_r;
	logic tokWrEn_r;
	logic [31:0] tokWrAddr_r;
	logic [31:0] tokWrData_r;
	logic mapValid_r [PAGES];
	ess_pkg::ess_ptype_t mapType_r [PAGES];
	logic [2:0] mapPerm_r [PAGES];
	logic [31:0] mapLa_r [PAGES];

	// Decode results
	logic cmdGo;
	ess_pkg::ess_op_t op;
	ess_pkg::ess_res_t res;
	ess_pkg::ess_ptype_t tgtType;
	ess_pkg::ess_ptype_t slotType;
	ess_pkg::ess_ptype_t hitType;
	logic [2:0] tgtPerm;
	logic [2:0] hitPerm;
	logic infoPresent;
	logic edgePos;
	logic slotBusy;
	logic hit;
	logic doMapWr;
	logic doPerm;
	logic doTok;
	logic doGp;
	logic doPf;
	logic [2:0] newPerm;
	ess_pkg::ess_ptype_t newType;

	ess_chk_if chkBus ();

	// ==========================================================
	// Helpers
	function automatic logic isShadow(input ess_pkg::ess_ptype_t t);
		return (t == ess_pkg::PT_SS_HEAD) || (t == ess_pkg::PT_SS_TAIL);
	endfunction

	function automatic logic inRange(input logic [31:0] la, input logic [31:0] lo,
		input logic [31:0] hi);
		return (la >= lo) && (la < hi);
	endfunction

	// ==========================================================
	// Content checker
	assign chkBus.clear = cmdGo && (op == ess_pkg::OP_CLEAR);
	assign chkBus.wordValid = regWr && (regAddr == ess_pkg::OFS_CONTENT);
	assign chkBus.wordData = regWrData;
	assign chkBus.pageLa = tgtLa_r & ess_pkg::PAGE_MASK;

	ess_page_check uCheck (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.chk(chkBus.chk)
	);

	// ==========================================================
	// Operand decode
	assign cmdGo = regWr && (regAddr == ess_pkg::OFS_CMD);
	assign op = ess_pkg::ess_op_t'(regWrData[3:0]);
	assign tgtType = ess_pkg::ess_ptype_t'(info_r[ess_pkg::INFO_TYPE_LSB +: 3]);
	assign tgtPerm = info_r[ess_pkg::INFO_PERM_LSB +: 3];
	assign infoPresent = info_r[ess_pkg::INFO_PRESENT_BIT];
	assign slotBusy = mapValid_r[tgtSlot_r];
	assign slotType = mapType_r[tgtSlot_r];
	assign edgePos = ((tgtLa_r & ess_pkg::PAGE_MASK) == base_r)
		|| ((tgtLa_r & ess_pkg::PAGE_MASK) == (end_r - ess_pkg::PAGE_SIZE));

	// Map lookup for direct accesses
	always_comb begin
		hit = 1'b0;
		hitType = ess_pkg::PT_NONE;
		hitPerm = 3'h0;
		for (int i = 0; i < PAGES; i++) begin
			if (mapValid_r[i] && (mapLa_r[i] == (tgtLa_r & ess_pkg::PAGE_MASK))) begin
				hit = 1'b1;
				hitType = mapType_r[i];
				hitPerm = mapPerm_r[i];
			end
		end
	end

	// ==========================================================
	// Command checks; every verdict settles before any commit
	always_comb begin
		res = ess_pkg::RES_OK;
		doMapWr = 1'b0;
		doPerm = 1'b0;
		doTok = 1'b0;
		doGp = 1'b0;
		doPf = 1'b0;
		newType = tgtType;
		newPerm = tgtPerm;
		unique case (op)
			ess_pkg::OP_NOP, ess_pkg::OP_CLEAR: begin
				res = ess_pkg::RES_OK;
			end
			ess_pkg::OP_ENTER: begin
				if (inEncl_r) res = ess_pkg::RES_ERR_MODE;
			end
			ess_pkg::OP_EXIT, ess_pkg::OP_AEX: begin
				if (!inEncl_r) res = ess_pkg::RES_ERR_MODE;
			end
			ess_pkg::OP_ADD: begin
				if (slotBusy) begin
					res = ess_pkg::RES_ERR_PARAM;
				end else if (isShadow(tgtType) && edgePos) begin
					res = ess_pkg::RES_ERR_POS;
				end else if (tgtType == ess_pkg::PT_SS_TAIL && !chkBus.restZero) begin
					res = ess_pkg::RES_ERR_CONTENT;
				end else if (tgtType == ess_pkg::PT_SS_HEAD && !chkBus.firstOk) begin
					res = ess_pkg::RES_ERR_CONTENT;
				end else if (tgtType == ess_pkg::PT_TCS && tcsNew_r != ess_pkg::RST_WORD) begin
					res = ess_pkg::RES_ERR_TCS;
				end else begin
					doMapWr = 1'b1;
				end
			end
			ess_pkg::OP_AUG: begin
				if (slotBusy) begin
					res = ess_pkg::RES_ERR_PARAM;
				end else if (!infoPresent) begin
					newType = ess_pkg::PT_REG;
					newPerm = ess_pkg::PERM_RW;
					doMapWr = 1'b1;
				end else if (!(tgtType == ess_pkg::PT_REG || isShadow(tgtType))
					|| tgtPerm != ess_pkg::PERM_RW) begin
					res = ess_pkg::RES_ERR_PARAM;
				end else if (isShadow(tgtType) && edgePos) begin
					res = ess_pkg::RES_ERR_POS;
				end else begin
					doMapWr = 1'b1;
					doTok = (tgtType == ess_pkg::PT_SS_HEAD);
				end
			end
			ess_pkg::OP_ACCEPT: begin
				if (!slotBusy) begin
					res = ess_pkg::RES_ERR_PARAM;
				end else if (slotType == ess_pkg::PT_TCS && tcsNew_r != ess_pkg::RST_WORD) begin
					res = ess_pkg::RES_ERR_TCS;
				end
			end
			ess_pkg::OP_ACCEPT_COPY, ess_pkg::OP_RESTRICT, ess_pkg::OP_EXTEND: begin
				if (!slotBusy) begin
					res = ess_pkg::RES_ERR_PARAM;
				end else if (isShadow(slotType)) begin
					res = ess_pkg::RES_ERR_TYPE;
				end else begin
					doPerm = (op != ess_pkg::OP_ACCEPT_COPY);
				end
			end
			ess_pkg::OP_ACCESS: begin
				if (inEncl_r) begin
					if (accKind_r[1] && !inRange(tgtLa_r, base_r, end_r)) begin
						doGp = 1'b1;
					end else if (inRange(tgtLa_r, base_r, end_r)) begin
						if (!hit) begin
							doPf = 1'b1;
						end else if (accKind_r[1]) begin
							doPf = !isShadow(hitType);
						end else if (accKind_r == ess_pkg::ACC_STORE) begin
							doPf = isShadow(hitType) || hitType != ess_pkg::PT_REG
								|| !hitPerm[ess_pkg::PERM_W_BIT];
						end else begin
							doPf = !(isShadow(hitType) || (hitType == ess_pkg::PT_REG
								&& hitPerm[ess_pkg::PERM_R_BIT]));
						end
					end
				end
				if (doGp) res = ess_pkg::RES_FAULT_GP;
				else if (doPf) res = ess_pkg::RES_FAULT_PF;
			end
			default: begin
				res = ess_pkg::RES_ERR_PARAM;
			end
		endcase
	end

	// ==========================================================
	// Page map updates
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < PAGES; i++) begin
				mapValid_r[i] <= 1'b0;
				mapType_r[i] <= ess_pkg::PT_NONE;
				mapPerm_r[i] <= 3'h0;
				mapLa_r[i] <= ess_pkg::RST_WORD;
			end
		end else if (cmdGo && doMapWr) begin
			mapValid_r[tgtSlot_r] <= 1'b1;
			mapType_r[tgtSlot_r] <= newType;
			mapPerm_r[tgtSlot_r] <= newPerm;
			mapLa_r[tgtSlot_r] <= tgtLa_r & ess_pkg::PAGE_MASK;
		end else if (cmdGo && doPerm) begin
			if (op == ess_pkg::OP_RESTRICT) begin
				mapPerm_r[tgtSlot_r] <= mapPerm_r[tgtSlot_r] & tgtPerm;
			end else begin
				mapPerm_r[tgtSlot_r] <= mapPerm_r[tgtSlot_r] | tgtPerm;
			end
		end
	end

	// ==========================================================
	// Protection state swap on entry and exit
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfLive_r <= ess_pkg::RST_WORD;
			cfScratch_r <= ess_pkg::RST_WORD;
			ssp_r <= ess_pkg::RST_WORD;
			tcsPrev_r <= ess_pkg::RST_WORD;
			ssaCf_r <= ess_pkg::RST_WORD;
			ssaSsp_r <= ess_pkg::RST_WORD;
			inEncl_r <= 1'b0;
		end else if (cmdGo && res == ess_pkg::RES_OK && op == ess_pkg::OP_ENTER) begin
			cfScratch_r <= cfLive_r;
			cfLive_r <= cfEncl_r;
			ssp_r <= tcsPrev_r;
			inEncl_r <= 1'b1;
		end else if (cmdGo && res == ess_pkg::RES_OK
			&& (op == ess_pkg::OP_EXIT || op == ess_pkg::OP_AEX)) begin
			if (op == ess_pkg::OP_AEX) begin
				ssaCf_r <= cfLive_r;
				ssaSsp_r <= ssp_r;
			end
			tcsPrev_r <= ssp_r;
			cfLive_r <= cfScratch_r;
			inEncl_r <= 1'b0;
		end else if (regWr) begin
			if (regAddr == ess_pkg::OFS_CF_LIVE) cfLive_r <= regWrData;
			if (regAddr == ess_pkg::OFS_SSP) ssp_r <= regWrData;
			if (regAddr == ess_pkg::OFS_TCS_PREV) tcsPrev_r <= regWrData;
		end
	end

	// ==========================================================
	// Software configuration registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			base_r <= ess_pkg::RST_WORD;
			end_r <= ess_pkg::RST_WORD;
			tgtLa_r <= ess_pkg::RST_WORD;
			tgtSlot_r <= '0;
			info_r <= 9'h000;
			cfEncl_r <= ess_pkg::RST_WORD;
			tcsNew_r <= ess_pkg::RST_WORD;
			accKind_r <= ess_pkg::ACC_LOAD;
		end else if (regWr) begin
			if (regAddr == ess_pkg::OFS_RANGE_BASE) base_r <= regWrData & ess_pkg::PAGE_MASK;
			if (regAddr == ess_pkg::OFS_RANGE_END) end_r <= regWrData & ess_pkg::PAGE_MASK;
			if (regAddr == ess_pkg::OFS_TGT_LA) tgtLa_r <= regWrData;
			if (regAddr == ess_pkg::OFS_TGT_SLOT) tgtSlot_r <= regWrData[SLOT_W-1:0];
			if (regAddr == ess_pkg::OFS_PAGE_INFO) info_r <= regWrData[8:0];
			if (regAddr == ess_pkg::OFS_CF_ENCL) cfEncl_r <= regWrData;
			if (regAddr == ess_pkg::OFS_TCS_NEW) tcsNew_r <= regWrData;
			if (regAddr == ess_pkg::OFS_ACC_KIND) accKind_r <= ess_pkg::ess_acc_t'(regWrData[1:0]);
		end
	end

	// ==========================================================
	// Result, fault and token outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			res_r <= ess_pkg::RES_OK;
			faultGp_r <= 1'b0;
			faultPf_r <= 1'b0;
			pfec_r <= ess_pkg::RST_WORD;
			tokWrEn_r <= 1'b0;
			tokWrAddr_r <= ess_pkg::RST_WORD;
			tokWrData_r <= ess_pkg::RST_WORD;
		end else begin
			faultGp_r <= cmdGo && doGp;
			faultPf_r <= cmdGo && doPf;
			tokWrEn_r <= cmdGo && doTok;
			if (cmdGo) begin
				res_r <= res;
			end
			if (cmdGo && doGp) begin
				pfec_r <= ess_pkg::RST_WORD;
			end else if (cmdGo && doPf) begin
				pfec_r <= ess_pkg::RST_WORD;
				pfec_r[ess_pkg::PFEC_ENCL_BIT] <= 1'b1;
				pfec_r[ess_pkg::PFEC_P_BIT] <= hit;
				pfec_r[ess_pkg::PFEC_WR_BIT] <= accKind_r[0];
			end
			if (cmdGo && doTok) begin
				tokWrAddr_r <= (tgtLa_r & ess_pkg::PAGE_MASK) + ess_pkg::TOKEN_OFS;
				tokWrData_r <= (tgtLa_r & ess_pkg::PAGE_MASK) + ess_pkg::PAGE_SIZE;
			end
		end
	end

	// ==========================================================
	// Register read port, data one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !regRd) begin
			rdData_r <= ess_pkg::RST_WORD;
		end else begin
			unique case (regAddr)
				ess_pkg::OFS_STATUS: rdData_r <= {27'h0, inEncl_r, res_r};
				ess_pkg::OFS_RANGE_BASE: rdData_r <= base_r;
				ess_pkg::OFS_RANGE_END: rdData_r <= end_r;
				ess_pkg::OFS_TGT_LA: rdData_r <= tgtLa_r;
				ess_pkg::OFS_TGT_SLOT: rdData_r <= 32'(tgtSlot_r);
				ess_pkg::OFS_PAGE_INFO: rdData_r <= {23'h0, info_r};
				ess_pkg::OFS_CF_LIVE: rdData_r <= cfLive_r;
				ess_pkg::OFS_CF_ENCL: rdData_r <= cfEncl_r;
				ess_pkg::OFS_SSP: rdData_r <= ssp_r;
				ess_pkg::OFS_TCS_PREV: rdData_r <= tcsPrev_r;
				ess_pkg::OFS_SSA_CF: rdData_r <= ssaCf_r;
				ess_pkg::OFS_SSA_SSP: rdData_r <= ssaSsp_r;
				ess_pkg::OFS_ACC_KIND: rdData_r <= {30'h0, accKind_r};
				ess_pkg::OFS_PFEC: rdData_r <= pfec_r;
				ess_pkg::OFS_TCS_NEW: rdData_r <= tcsNew_r;
				ess_pkg::OFS_MAP_READ: rdData_r <= mapLa_r[tgtSlot_r]
					| {23'h0, mapValid_r[tgtSlot_r], 2'h0, mapType_r[tgtSlot_r], mapPerm_r[tgtSlot_r]};
				default: rdData_r <= ess_pkg::RST_WORD;
			endcase
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign regRdData = rdData_r;
	assign inEnclave = inEncl_r;
	assign cfLive = cfLive_r;
	assign sspLive = ssp_r;
	assign faultGp = faultGp_r;
	assign faultPf = faultPf_r;
	assign pfecOut = pfec_r;
	assign tokWrEn = tokWrEn_r;
	assign tokWrAddr = tokWrAddr_r;
	assign tokWrData = tokWrData_r;
endmodule
`default_nettype wire

// >>> sim/ess_shadow_ctrl_test.sv
// Self-checking bench for the shadow-stack control block
`timescale 1ns/10ps
`default_nettype none
module ess_shadow_ctrl_test;
	// ==========================================================
	// Design ports and bench state
	logic clk_sys, rst_n, regWr, regRd, inEnclave, faultGp, faultPf, tokWrEn;
	logic gp, pf, tk;
	bit em;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData, cfLive, sspLive, pfecOut, tokWrAddr, tokWrData, rdv;
	int miscompares;
	int samples_checked;
	int cycles;

	ess_shadow_ctrl #(.PAGES(16)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .inEnclave(inEnclave),
		.cfLive(cfLive), .sspLive(sspLive), .faultGp(faultGp), .faultPf(faultPf),
		.pfecOut(pfecOut), .tokWrEn(tokWrEn), .tokWrAddr(tokWrAddr), .tokWrData(tokWrData));

	// 25 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		rdv = regRdData;
		chk(rdv, exp);
	endtask
	task automatic cmd(input logic [3:0] o, input logic [3:0] r);
		wr(ess_pkg::OFS_CMD, {28'h0, o});
		gp = faultGp;
		pf = faultPf;
		tk = tokWrEn;
		if (r == ess_pkg::RES_OK && o inside {[1:3]}) em = (o == 4'h1);
		chk({31'h0, inEnclave}, {31'h0, em});
		rc(ess_pkg::OFS_STATUS, {27'h0, em, r});
	endtask
	task automatic pg(input logic [31:0] la, input logic [31:0] slot, input logic [31:0] info);
		wr(ess_pkg::OFS_TGT_LA, la);
		wr(ess_pkg::OFS_TGT_SLOT, slot);
		wr(ess_pkg::OFS_PAGE_INFO, info);
	endtask
	// Stream a page, place it, check result and map slot
	task automatic addc(input logic [31:0] la, input logic [31:0] slot, input logic [31:0] info,
		input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] thread_control_struct,
		input logic [3:0] r, input logic [31:0] map);
		wr(ess_pkg::OFS_TCS_NEW, thread_control_struct);
		wr(ess_pkg::OFS_CMD, {28'h0, ess_pkg::OP_CLEAR});
		for (int i = 0; i < 1024; i++) begin
			wr(ess_pkg::OFS_CONTENT, i == 1022 ? lo : (i == 1023 ? hi : 32'h0));
		end
		pg(la, slot, info);
		cmd(ess_pkg::OP_ADD, r);
		rc(ess_pkg::OFS_MAP_READ, map);
	endtask
	task automatic acc(input logic [1:0] k, input logic [31:0] la, input logic [3:0] r,
		input logic g, input logic p);
		wr(ess_pkg::OFS_ACC_KIND, {30'h0, k});
		wr(ess_pkg::OFS_TGT_LA, la);
		cmd(ess_pkg::OP_ACCESS, r);
		chk({31'h0, gp}, {31'h0, g});
		chk({31'h0, pf}, {31'h0, p});
	endtask
	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 45000) begin
			miscompares++;
			$display("Error at %0t: timeout", $time);
			end_sim();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		rc(8'h7c, 32'h0);
		wr(ess_pkg::OFS_RANGE_BASE, 32'h0001_0000);
		wr(ess_pkg::OFS_RANGE_END, 32'h0002_0000);
		// Augment cases
		pg(32'h0001_0000, 0, 32'h11b);
		cmd(ess_pkg::OP_AUG, ess_pkg::RES_ERR_POS);
		pg(32'h0001_1000, 0, 32'h119);
		cmd(ess_pkg::OP_AUG, ess_pkg::RES_ERR_PARAM);
		rc(ess_pkg::OFS_MAP_READ, 32'h0);
		pg(32'h0001_1000, 0, 32'h11b);
		cmd(ess_pkg::OP_AUG, ess_pkg::RES_OK);
		chk({31'h0, tk}, 32'h1);
		chk(tokWrAddr, 32'h0001_1ff8);
		chk(tokWrData, 32'h0001_2000);
		rc(ess_pkg::OFS_MAP_READ, 32'h0001_111b);
		pg(32'h0001_2000, 1, 32'h0);
		cmd(ess_pkg::OP_AUG, ess_pkg::RES_OK);
		rc(ess_pkg::OFS_MAP_READ, 32'h0001_210b);
		pg(32'h0001_6000, 5, 32'h10b);
		cmd(ess_pkg::OP_AUG, ess_pkg::RES_OK);
		// Add cases
		addc(32'h1f000, 2, 32'h123, 0, 0, 0, ess_pkg::RES_ERR_POS, 0);
		addc(32'h13000, 2, 32'h123, 0, 1, 0, ess_pkg::RES_ERR_CONTENT, 0);
		addc(32'h13000, 2, 32'h123, 0, 0, 0, ess_pkg::RES_OK, 32'h13123);
		addc(32'h14000, 3, 32'h11b, 32'h14ff8, 0, 0, ess_pkg::RES_ERR_CONTENT, 0);
		addc(32'h14000, 3, 32'h11b, 32'h15000, 1, 0, ess_pkg::RES_ERR_CONTENT, 0);
		addc(32'h14000, 3, 32'h11b, 32'h15000, 0, 0, ess_pkg::RES_OK, 32'h1411b);
		addc(32'h15000, 4, 32'h110, 0, 0, 5, ess_pkg::RES_ERR_TCS, 0);
		addc(32'h15000, 4, 32'h110, 0, 0, 0, ess_pkg::RES_OK, 32'h15110);
		wr(ess_pkg::OFS_TCS_NEW, 32'h3);
		cmd(ess_pkg::OP_ACCEPT, ess_pkg::RES_ERR_TCS);
		// Copy, restrict and extend on a shadow page, then restrict on an ordinary page
		pg(32'h0001_1000, 0, 32'h100);
		for (int o = 7; o <= 9; o++) begin
			cmd(o[3:0], ess_pkg::RES_ERR_TYPE);
		end
		rc(ess_pkg::OFS_MAP_READ, 32'h0001_111b);
		pg(32'h0001_2000, 1, 32'h101);
		cmd(ess_pkg::OP_RESTRICT, ess_pkg::RES_OK);
		rc(ess_pkg::OFS_MAP_READ, 32'h0001_2109);
		// Entry and accesses
		wr(ess_pkg::OFS_CF_LIVE, 32'ha5);
		wr(ess_pkg::OFS_CF_ENCL, 32'h5a);
		wr(ess_pkg::OFS_TCS_PREV, 32'h0001_1ff0);
		cmd(ess_pkg::OP_ENTER, ess_pkg::RES_OK);
		chk(cfLive, 32'h5a);
		chk(sspLive, 32'h0001_1ff0);
		acc(ess_pkg::ACC_SS_STORE, 32'h30000, ess_pkg::RES_FAULT_GP, 1, 0);
		rc(ess_pkg::OFS_PFEC, 32'h0);
		acc(ess_pkg::ACC_SS_LOAD, 32'h20000, ess_pkg::RES_FAULT_GP, 1, 0);
		acc(ess_pkg::ACC_SS_LOAD, 32'h11000, ess_pkg::RES_OK, 0, 0);
		acc(ess_pkg::ACC_LOAD, 32'h11000, ess_pkg::RES_OK, 0, 0);
		acc(ess_pkg::ACC_SS_STORE, 32'h13000, ess_pkg::RES_OK, 0, 0);
		acc(ess_pkg::ACC_STORE, 32'h11000, ess_pkg::RES_FAULT_PF, 0, 1);
		rc(ess_pkg::OFS_PFEC, 32'h8003);
		acc(ess_pkg::ACC_SS_LOAD, 32'h12000, ess_pkg::RES_FAULT_PF, 0, 1);
		// Exits
		cmd(ess_pkg::OP_AEX, ess_pkg::RES_OK);
		chk(cfLive, 32'ha5);
		rc(ess_pkg::OFS_SSA_CF, 32'h5a);
		rc(ess_pkg::OFS_TCS_PREV, 32'h0001_1ff0);
		cmd(ess_pkg::OP_ENTER, ess_pkg::RES_OK);
		wr(ess_pkg::OFS_SSP, 32'h0001_1fe8);
		cmd(ess_pkg::OP_EXIT, ess_pkg::RES_OK);
		chk(cfLive, 32'ha5);
		rc(ess_pkg::OFS_TCS_PREV, 32'h0001_1fe8);
		cmd(ess_pkg::OP_EXIT, ess_pkg::RES_ERR_MODE);
		end_sim();
	end
endmodule
`default_nettype wire

// >>> sim/ess_shadow_properties.sv
// Port-level assertions for the shadow-stack control block
`timescale 1ns/10ps
`default_nettype none
module ess_shadow_properties #(
	parameter int PAGES = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	// Core state and faults
	input wire logic inEnclave,
	input wire logic [31:0] cfLive,
	input wire logic [31:0] sspLive,
	input wire logic faultGp,
	input wire logic faultPf,
	input wire logic [31:0] pfecOut,
	// Token write
	input wire logic tokWrEn,
	input wire logic [31:0] tokWrAddr,
	input wire logic [31:0] tokWrData
);
	// ==========================================================
	// Command decode
	logic isCmd, augCmd, accCmd, enterCmd, exitCmd;
	logic [31:0] encCf_r, hostCf_r, saved_shadow_ptr_field_r;
	assign isCmd = regWr && regAddr == ess_pkg::OFS_CMD;
	assign augCmd = isCmd && regWrData[3:0] == ess_pkg::OP_AUG;
	assign accCmd = isCmd && regWrData[3:0] == ess_pkg::OP_ACCESS;
	assign enterCmd = isCmd && regWrData[3:0] == ess_pkg::OP_ENTER && !inEnclave;
	assign exitCmd = isCmd && inEnclave
		&& (regWrData[3:0] == ess_pkg::OP_EXIT || regWrData[3:0] == ess_pkg::OP_AEX);

	// Enclave configuration as last written
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			encCf_r <= ess_pkg::RST_WORD;
		end else if (regWr && regAddr == ess_pkg::OFS_CF_ENCL) begin
			encCf_r <= regWrData;
		end
	end
	// Host state seen at entry
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hostCf_r <= ess_pkg::RST_WORD;
		end else if (enterCmd) begin
			hostCf_r <= cfLive;
		end
	end
	// Saved pointer field: software write or exit
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			saved_shadow_ptr_field_r <= ess_pkg::RST_WORD;
		end else if (regWr && regAddr == ess_pkg::OFS_TCS_PREV) begin
			saved_shadow_ptr_field_r <= regWrData;
		end else if (exitCmd) begin
			saved_shadow_ptr_field_r <= sspLive;
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence sEnter;
		enterCmd ##1 inEnclave;
	endsequence
	sequence sExit;
		exitCmd ##1 !inEnclave;
	endsequence
	chk_enter_mode: assert property (enterCmd |=> inEnclave)
		else $error("enter did not set enclave mode");
	chk_enter_cf: assert property (sEnter |-> cfLive == encCf_r)
		else $error("enclave config not loaded");
	chk_enter_ssp: assert property (sEnter |-> sspLive == saved_shadow_ptr_field_r)
		else $error("pointer not loaded from field");
	chk_exit_host: assert property (sExit |-> cfLive == hostCf_r)
		else $error("host state not restored");
	chk_token_pair: assert property (tokWrEn |-> tokWrData == tokWrAddr + 32'h8
		&& tokWrAddr[11:0] == 12'hff8)
		else $error("token address or value wrong");
	chk_token_cause: assert property (tokWrEn |-> $past(augCmd))
		else $error("token write without augment");
	chk_gp_code: assert property (faultGp |-> !faultPf && pfecOut == 32'h0)
		else $error("general fault code not zero");
	chk_pf_encl: assert property (faultPf |-> pfecOut[ess_pkg::PFEC_ENCL_BIT])
		else $error("page fault lacks enclave bit");
	chk_fault_mode: assert property ((faultGp || faultPf)
		|-> $past(accCmd) && $past(inEnclave))
		else $error("fault outside enclave access");
	chk_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data outside read cycle");
endmodule

bind ess_shadow_ctrl ess_shadow_properties #(.PAGES(PAGES)) u_props (
	.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .inEnclave(inEnclave),
	.cfLive(cfLive), .sspLive(sspLive), .faultGp(faultGp), .faultPf(faultPf),
	.pfecOut(pfecOut), .tokWrEn(tokWrEn), .tokWrAddr(tokWrAddr), .tokWrData(tokWrData));
`default_nettype wire
